// ==== design/status_indicator_pkg.sv ====
package status_indicator_pkg;
	localparam int unsigned CLOCK_HZ = 100_000_000;
	localparam int unsigned CLOCK_NS = 10;
	// display link poll interval with no display fitted
	localparam int unsigned DISPLAY_POLL_MS = 2000;
	localparam int unsigned DISPLAY_POLL_CYCLES = DISPLAY_POLL_MS * (CLOCK_HZ / 1000);
	// visible flash stretch and blink half period
	localparam int unsigned STRETCH_MS = 50;
	localparam int unsigned STRETCH_CYCLES = STRETCH_MS * (CLOCK_HZ / 1000);
	localparam int unsigned BLINK_MS = 250;
	localparam int unsigned BLINK_CYCLES = BLINK_MS * (CLOCK_HZ / 1000);
	// button debounce time
	localparam int unsigned DEBOUNCE_MS = 20;
	localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLOCK_HZ / 1000);
	localparam int unsigned COUNT_W = 28;

	// Wishbone register map (byte addresses)
	localparam logic [7:0] CONTROL_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	localparam logic [7:0] EVENT_ADDR = 8'h08;
	// control register fields
	localparam int unsigned CTRL_BOOT_DONE = 0;
	localparam int unsigned CTRL_CODE_VALID = 1;
	localparam int unsigned CTRL_HW_FAULT = 2;
	localparam int unsigned CTRL_REBOOT_NEEDED = 3;
	localparam int unsigned CTRL_DISPLAY_FITTED = 4;
	localparam int unsigned CTRL_IDENT_CLEAR = 5;
	localparam int unsigned CTRL_W = 6;
	localparam logic [CTRL_W-1:0] CONTROL_RESET = 6'h00;
	// event register: write one to pulse
	localparam int unsigned EV_ALARM_ACK = 0;
	localparam int unsigned EV_SOFT_REBOOT = 1;

	typedef enum logic [2:0]
	{
		alarm_normal = 3'b001,
		alarm_active = 3'b010,
		alarm_acked = 3'b100
	} alarm_state_t;

	typedef struct packed
	{
		logic display_attempt;
		logic heartbeat;
		logic host_rx;
		logic host_tx;
		logic field_rx;
		logic module_traffic;
		logic relay_on;
		logic alarm_cond;
		logic alarm_raise;
		logic link_up;
	} status_in_t;

	typedef struct packed
	{
		logic display_link_send_led;
		logic heartbeat_led;
		logic code_led;
		logic host_serial_receive_led;
		logic host_serial_send_led;
		logic relay_output_led;
		logic service_led;
		logic field_traffic_led;
		logic link_led;
		logic module_traffic_led;
		logic alarm_green;
		logic alarm_red;
	} led_out_t;
endpackage

// ==== design/activity_stretch.sv ====
`timescale 1ns/10ps
module activity_stretch #(
	parameter int unsigned LENGTH = status_indicator_pkg::STRETCH_CYCLES
)
(
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_event,
	output logic o_led
);
	logic [status_indicator_pkg::COUNT_W-1:0] count;
	logic [status_indicator_pkg::COUNT_W-1:0] next_count;

	// each event restarts the pulse; a burst reads as one long flash
	always_comb
	begin
		next_count = count;
		if (i_event)
			next_count = status_indicator_pkg::COUNT_W'(LENGTH);
		else if (count != '0)
			next_count = count - 1'b1;
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_b)
			count <= '0;
		else
			count <= next_count;
	end

	assign o_led = (count != '0);
endmodule // activity_stretch

// ==== design/button_filter.sv ====
`timescale 1ns/10ps
module button_filter #(
	parameter int unsigned SETTLE = status_indicator_pkg::DEBOUNCE_CYCLES
)
(
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_button_b,
	output logic o_press
);
	logic sync_a;
	logic sync_b;
	logic stable;
	logic [status_indicator_pkg::COUNT_W-1:0] count;
	logic next_sync_a;
	logic next_sync_b;
	logic next_stable;
	logic [status_indicator_pkg::COUNT_W-1:0] next_count;

	// pin is active low; two flops before the filter reads it
	always_comb
	begin
		next_sync_a = ~i_button_b;
		next_sync_b = sync_a;
		next_stable = stable;
		next_count = '0;
		if (sync_b != stable)
		begin
			next_count = count + 1'b1;
			if (count == status_indicator_pkg::COUNT_W'(SETTLE))
			begin
				next_stable = sync_b;
				next_count = '0;
			end
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_b)
		begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			stable <= 1'b0;
			count <= '0;
		end
		else
		begin
			sync_a <= next_sync_a;
			sync_b <= next_sync_b;
			stable <= next_stable;
			count <= next_count;
		end
	end

	assign o_press = next_stable & ~stable;
endmodule // button_filter

// ==== design/status_indicator_controller.sv ====
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
// Behaviour
// - display send led flashes on every display-link attempt, fitted or not.
// - with no display fitted, attempts and flashes recur every two seconds.
// - heartbeat led steady during boot, then flashes with processor activity.
// - code led steady while booting or code missing; download allowed then.
// - host receive led off normally, flashes on host serial receive.
// - host send led off normally, flashes on host serial send.
// - relay led flashes while relay energised and alarm condition present.
// - service led steady on hardware fault or after identify press.
// - service led flashes when a reboot is required.
// - field traffic led flashes on field-link receive.
// - network left led lit while wired link detected.
// - network right led shows module to board serial traffic.
// - alarm led steady green in normal operation without pending alarm.
// - configured-severity alarm turns alarm led red and flashing.
// - alarm acknowledge clears red flashing and turns alarm led off.
// - reboot button reboots exactly as software reboot, losing volatile data.
// - identify press broadcasts node and program identifiers on field link.
module status_indicator_controller #(
	parameter int unsigned POLL_CYCLES = status_indicator_pkg::DISPLAY_POLL_CYCLES,
	parameter int unsigned STRETCH = status_indicator_pkg::STRETCH_CYCLES,
	parameter int unsigned BLINK = status_indicator_pkg::BLINK_CYCLES,
	parameter int unsigned SETTLE = status_indicator_pkg::DEBOUNCE_CYCLES
)
(
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire status_indicator_pkg::status_in_t i_status,
	input wire logic i_reboot_button_b,
	input wire logic i_identify_button_b,
	output status_indicator_pkg::led_out_t o_leds,
	output logic o_display_poll,
	output logic o_download_enable,
	output logic o_reboot_request,
	output logic o_identify_broadcast
);
	logic [status_indicator_pkg::CTRL_W-1:0] control;
	logic [status_indicator_pkg::CTRL_W-1:0] next_control;
	logic ack;
	logic next_ack;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic ev_ack;
	logic ev_reboot;
	logic ident_seen;
	logic next_ident_seen;
	logic [status_indicator_pkg::COUNT_W-1:0] poll_count;
	logic [status_indicator_pkg::COUNT_W-1:0] next_poll_count;
	logic [status_indicator_pkg::COUNT_W-1:0] blink_count;
	logic [status_indicator_pkg::COUNT_W-1:0] next_blink_count;
	logic blink;
	logic next_blink;
	status_indicator_pkg::alarm_state_t alarm;
	status_indicator_pkg::alarm_state_t next_alarm;
	status_indicator_pkg::led_out_t leds;
	status_indicator_pkg::led_out_t next_leds;
	logic poll;
	logic next_poll;
	logic reboot_req;
	logic next_reboot_req;
	logic ident_req;
	logic next_ident_req;
	logic reboot_press;
	logic ident_press;
	logic display_attempt;
	logic [5:0] stretched;
	logic booting;
	logic wb_write;

	// sync inputs from other logic on this clock need no synchroniser
	assign wb_write = i_wb_cyc & i_wb_stb & i_wb_we & ~ack;
	assign ev_ack = wb_write & i_wb_sel[0]
		& (i_wb_adr == status_indicator_pkg::EVENT_ADDR)
		& i_wb_dat[status_indicator_pkg::EV_ALARM_ACK];
	assign ev_reboot = wb_write & i_wb_sel[0]
		& (i_wb_adr == status_indicator_pkg::EVENT_ADDR)
		& i_wb_dat[status_indicator_pkg::EV_SOFT_REBOOT];
	assign booting = ~control[status_indicator_pkg::CTRL_BOOT_DONE];

	button_filter #(.SETTLE(SETTLE)) reboot_filter
	(
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_button_b(i_reboot_button_b),
		.o_press(reboot_press)
	);

	button_filter #(.SETTLE(SETTLE)) identify_filter
	(
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_button_b(i_identify_button_b),
		.o_press(ident_press)
	);

	// the firmware's attempts, plus own polls when no display
	assign display_attempt = i_status.display_attempt | poll;

	activity_stretch #(.LENGTH(STRETCH)) stretch_display
	(
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_event(display_attempt),
		.o_led(stretched[0])
	);

	activity_stretch #(.LENGTH(STRETCH)) stretch_heart
	(
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_event(i_status.heartbeat),
		.o_led(stretched[1])
	);

	activity_stretch #(.LENGTH(STRETCH)) stretch_host_rx
	(
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_event(i_status.host_rx),
		.o_led(stretched[2])
	);

	activity_stretch #(.LENGTH(STRETCH)) stretch_host_tx
	(
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_event(i_status.host_tx),
		.o_led(stretched[3])
	);

	activity_stretch #(.LENGTH(STRETCH)) stretch_field
	(
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_event(i_status.field_rx),
		.o_led(stretched[4])
	);

	activity_stretch #(.LENGTH(STRETCH)) stretch_module
	(
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_event(i_status.module_traffic),
		.o_led(stretched[5])
	);

	// register slave, blink divider, poll timer and identify latch
	always_comb
	begin
		next_control = control;
		next_ack = i_wb_cyc & i_wb_stb & ~ack;
		next_rdata = 32'h0000_0000;
		if (wb_write & i_wb_sel[0]
			& (i_wb_adr == status_indicator_pkg::CONTROL_ADDR))
			next_control = i_wb_dat[status_indicator_pkg::CTRL_W-1:0];
		unique case (i_wb_adr)
			status_indicator_pkg::CONTROL_ADDR:
				next_rdata = {26'h000_0000, control};
			status_indicator_pkg::STATUS_ADDR:
				next_rdata = {16'h0000, ident_seen, alarm, leds};
			default:
				next_rdata = 32'h0000_0000;
		endcase

		next_blink_count = blink_count + 1'b1;
		next_blink = blink;
		if (blink_count == status_indicator_pkg::COUNT_W'(BLINK - 1))
		begin
			next_blink_count = '0;
			next_blink = ~blink;
		end

		// poll runs only while no display is fitted
		next_poll = 1'b0;
		next_poll_count = poll_count + 1'b1;
		if (control[status_indicator_pkg::CTRL_DISPLAY_FITTED])
			next_poll_count = '0;
		else if (poll_count == status_indicator_pkg::COUNT_W'(POLL_CYCLES - 1))
		begin
			next_poll_count = '0;
			next_poll = 1'b1;
		end

		// a press in the clear cycle wins over the clear
		next_ident_seen = ident_seen;
		if (control[status_indicator_pkg::CTRL_IDENT_CLEAR])
			next_ident_seen = 1'b0;
		if (ident_press)
			next_ident_seen = 1'b1;

		next_ident_req = ident_press;
		// button and software reboot share one request
		next_reboot_req = reboot_press | ev_reboot;
	end

	// alarm state machine
	always_comb
	begin
		next_alarm = alarm;
		unique case (alarm)
			status_indicator_pkg::alarm_normal:
				if (i_status.alarm_raise)
					next_alarm = status_indicator_pkg::alarm_active;
			status_indicator_pkg::alarm_active:
				if (ev_ack & ~i_status.alarm_raise)
					next_alarm = status_indicator_pkg::alarm_acked;
			status_indicator_pkg::alarm_acked:
				if (i_status.alarm_raise)
					next_alarm = status_indicator_pkg::alarm_active;
			default:
				next_alarm = status_indicator_pkg::alarm_normal;
		endcase
	end

	// led drive
	always_comb
	begin
		next_leds.display_link_send_led = stretched[0];
		next_leds.heartbeat_led = booting | stretched[1];
		next_leds.code_led = booting
			| ~control[status_indicator_pkg::CTRL_CODE_VALID];
		next_leds.host_serial_receive_led = stretched[2];
		next_leds.host_serial_send_led = stretched[3];
		next_leds.relay_output_led = i_status.relay_on
			& i_status.alarm_cond & blink;
		// reboot flashing takes priority over steady service states
		if (control[status_indicator_pkg::CTRL_REBOOT_NEEDED])
			next_leds.service_led = blink;
		else
			next_leds.service_led = control[status_indicator_pkg::CTRL_HW_FAULT]
				| ident_seen;
		next_leds.field_traffic_led = stretched[4];
		next_leds.link_led = i_status.link_up;
		next_leds.module_traffic_led = stretched[5];
		next_leds.alarm_green =
			(alarm == status_indicator_pkg::alarm_normal);
		next_leds.alarm_red =
			(alarm == status_indicator_pkg::alarm_active) & blink;
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_b)
		begin
			control <= status_indicator_pkg::CONTROL_RESET;
			ack <= 1'b0;
			rdata <= 32'h0000_0000;
			blink_count <= '0;
			blink <= 1'b0;
			poll_count <= '0;
			poll <= 1'b0;
			ident_seen <= 1'b0;
			ident_req <= 1'b0;
			reboot_req <= 1'b0;
			alarm <= status_indicator_pkg::alarm_normal;
			leds <= '0;
		end
		else
		begin
			control <= next_control;
			ack <= next_ack;
			rdata <= next_rdata;
			blink_count <= next_blink_count;
			blink <= next_blink;
			poll_count <= next_poll_count;
			poll <= next_poll;
			ident_seen <= next_ident_seen;
			ident_req <= next_ident_req;
			reboot_req <= next_reboot_req;
			alarm <= next_alarm;
			leds <= next_leds;
		end
	end

	assign o_wb_ack = ack;
	assign o_wb_dat = rdata;
	assign o_leds = leds;
	assign o_display_poll = poll;
	assign o_download_enable = leds.code_led;
	assign o_reboot_request = reboot_req;
	assign o_identify_broadcast = ident_req;
endmodule // status_indicator_controller

// ==== tb/status_indicator_props.sv ====
`timescale 1ns/10ps
module status_indicator_props (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire status_indicator_pkg::status_in_t i_status,
	input wire status_indicator_pkg::led_out_t o_leds,
	input wire logic o_display_poll,
	input wire logic o_download_enable
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	// stretch of 4 matches the bench's STRETCH setting
	host_rx_stretch_a: assert property (i_status.host_rx |-> ##2
		o_leds.host_serial_receive_led[*4]) else $error("receive led short");
	host_tx_stretch_a: assert property (i_status.host_tx |-> ##2
		o_leds.host_serial_send_led[*4]) else $error("send led short");
	field_rx_flash_a: assert property (i_status.field_rx |-> ##2
		o_leds.field_traffic_led[*4]) else $error("field led short");
	module_traffic_a: assert property (i_status.module_traffic |-> ##2
		o_leds.module_traffic_led[*4]) else $error("module led short");
	link_led_a: assert property (i_status.link_up[*2] |=>
		o_leds.link_led) else $error("link led off with link up");
	download_follows_a: assert property (o_download_enable ==
		o_leds.code_led) else $error("download enable differs from code led");
	one_colour_a: assert property (!(o_leds.alarm_red &&
		o_leds.alarm_green)) else $error("alarm led red and green");
	alarm_green_off_a: assert property (i_status.alarm_raise |-> ##3
		(!o_leds.alarm_green)[*2]) else $error("green after alarm");
	poll_spacing_a: assert property (o_display_poll |=>
		(!o_display_poll)[*8]) else $error("display poll too soon");
endmodule // status_indicator_props
bind status_indicator_controller status_indicator_props props_i (.i_clock,
	.i_rst_b, .i_status, .o_leds, .o_display_poll, .o_download_enable);

// ==== tb/status_source.sv ====
`timescale 1ns/10ps
module status_source (
	input wire logic i_clock,
	input wire logic i_enable,
	input wire status_indicator_pkg::status_in_t i_mask,
	output status_indicator_pkg::status_in_t o_status
);
	// a fresh random pattern each cycle gives back-to-back and retriggered
	// events, which a tidy source would never show
	always @(posedge i_clock)
	begin
		if (i_enable)
			o_status <= i_mask & 10'($urandom);
		else
			o_status <= '0;
	end
endmodule // status_source

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb;
	logic i_clock, i_rst_b, cyc, stb, we, ack, poll, dl, rq, idb, en, rb_b, id_b;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, rd, v;
	status_indicator_pkg::status_in_t man, src, mask;
	status_indicator_pkg::led_out_t leds;
	int n_mismatch, samples_checked, cyc_n, last_poll, gap, n_id, n_rq, cnt;
	int ev[6] = '{9, 8, 7, 6, 5, 4};
	int lt[6] = '{11, 10, 8, 7, 4, 2};

	status_indicator_controller #(.POLL_CYCLES(50), .STRETCH(4), .BLINK(3),
		.SETTLE(2)) status_indicator_controller_i (.i_clock, .i_rst_b,
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_status(man | src), .i_reboot_button_b(rb_b),
		.i_identify_button_b(id_b), .o_leds(leds), .o_display_poll(poll),
		.o_download_enable(dl), .o_reboot_request(rq),
		.o_identify_broadcast(idb));
	status_source status_source_i (.i_clock, .i_enable(en), .i_mask(mask),
		.o_status(src));

	initial
	begin
		i_clock = 1'h0;
		forever #5 i_clock = ~i_clock;
	end

	function automatic status_indicator_pkg::led_out_t boot_leds();
		status_indicator_pkg::led_out_t e;
		e = '0;
		e.code_led = 1'h1;
		e.heartbeat_led = 1'h1;
		e.alarm_green = 1'h1;
		return e;
	endfunction

	task wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// ack is one cycle late; hold the request until it is seen
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		t = 0;
		do
		begin
			@(posedge i_clock);
			t++;
		end
		while (ack !== 1'h1 && t < 20);
		rd = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		@(posedge i_clock);
		if (t >= 20)
		begin
			n_mismatch++;
			wrap_up();
		end
	endtask

	task hi(input int l, input int n);
		cnt = 0;
		repeat (n)
		begin
			@(posedge i_clock);
			cnt += (leds[l] === 1'h1);
		end
	endtask

	task press(input int which);
		if (which)
			id_b <= 1'h0;
		else
			rb_b <= 1'h0;
		repeat (8) @(posedge i_clock);
		id_b <= 1'h1;
		rb_b <= 1'h1;
		repeat (8) @(posedge i_clock);
	endtask

	always @(posedge i_clock)
	begin
		cyc_n++;
		if (poll === 1'h1)
		begin
			gap = cyc_n - last_poll;
			last_poll = cyc_n;
		end
		n_id += (idb === 1'h1);
		n_rq += (rq === 1'h1);
	end

	initial
	begin
		repeat (20000) @(posedge i_clock);
		n_mismatch++;
		wrap_up();
	end

	initial
	begin
		{i_rst_b, cyc, stb, we, en, adr, wdat} = '0;
		{man, mask} = '0;
		{rb_b, id_b} = 2'h3;
		void'($urandom(32'h1C1B91EF));
		repeat (5) @(posedge i_clock);
		i_rst_b <= 1'h1;
		repeat (2) @(posedge i_clock);
		chk(leds, boot_leds());
		chk(dl, 1'h1);
		wb(1'h0, status_indicator_pkg::CONTROL_ADDR, 32'h0);
		chk(rd, 32'h0);
		wb(1'h0, 8'h0C, 32'h0);
		chk(rd, 32'h0);
		repeat (100) @(posedge i_clock);
		chk(gap, 50);
		wb(1'h1, status_indicator_pkg::CONTROL_ADDR, 32'h13);
		repeat (3) @(posedge i_clock);
		chk(leds.code_led, 1'h0);
		chk(dl, 1'h0);
		for (int i = 0; i < 6; i++)
		begin
			man[ev[i]] <= 1'h1;
			@(posedge i_clock);
			man[ev[i]] <= 1'h0;
			hi(lt[i], 12);
			chk(cnt, 4);
		end
		man.link_up <= 1'h1;
		hi(3, 6);
		chk(cnt >= 4, 1'h1);
		{man.link_up, man.relay_on, man.alarm_cond} <= 3'h3;
		hi(6, 20);
		chk(cnt > 0 && cnt < 20, 1'h1);
		man.alarm_cond <= 1'h0;
		repeat (3) @(posedge i_clock);
		hi(6, 10);
		chk(cnt, 0);
		man.relay_on <= 1'h0;
		wb(1'h1, status_indicator_pkg::CONTROL_ADDR, 32'h17);
		hi(5, 10);
		chk(cnt, 10);
		wb(1'h1, status_indicator_pkg::CONTROL_ADDR, 32'h1B);
		hi(5, 20);
		chk(cnt > 0 && cnt < 20, 1'h1);
		wb(1'h1, status_indicator_pkg::CONTROL_ADDR, 32'h33);
		wb(1'h1, status_indicator_pkg::CONTROL_ADDR, 32'h13);
		press(1);
		chk(n_id, 1);
		hi(5, 4);
		chk(cnt, 4);
		wb(1'h0, status_indicator_pkg::STATUS_ADDR, 32'h0);
		chk(rd[15], 1'h1);
		i_rst_b <= 1'h0;
		repeat (2) @(posedge i_clock);
		i_rst_b <= 1'h1;
		repeat (2) @(posedge i_clock);
		chk(leds, boot_leds());
		press(0);
		chk(n_rq, 1);
		wb(1'h1, status_indicator_pkg::EVENT_ADDR, 32'h2);
		repeat (3) @(posedge i_clock);
		chk(n_rq, 2);
		man.alarm_raise <= 1'h1;
		@(posedge i_clock);
		man.alarm_raise <= 1'h0;
		hi(0, 20);
		chk(cnt > 0 && cnt < 20, 1'h1);
		chk(leds.alarm_green, 1'h0);
		wb(1'h1, status_indicator_pkg::EVENT_ADDR, 32'h1);
		repeat (3) @(posedge i_clock);
		chk(leds[1:0], 2'h0);
		wb(1'h0, status_indicator_pkg::STATUS_ADDR, 32'h0);
		chk(rd[14:12], 3'h4);
		en <= 1'h1;
		mask <= 10'h3F1;
		repeat (30)
		begin
			v = $urandom & 32'h3F;
			wb(1'h1, status_indicator_pkg::CONTROL_ADDR, v);
			wb(1'h0, status_indicator_pkg::CONTROL_ADDR, 32'h0);
			chk(rd[5:0], v[5:0]);
		end
		wrap_up();
	end
endmodule // tb
